// *** phcal_lane.sv ***
// One phase lane: delay line that shifts voltage samples by a step count.
// Assumes a one-cycle tick at the processing rate and a signed-magnitude value.
`default_nettype none
`include "phcal_params.svh"
module phcal_lane (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Sample stream
    input wire logic tick_in,
    input wire phcal_pkg::phcal_sample_t volt_in,
    input wire phcal_pkg::phcal_cal_t cal_in,
    output logic [`PHCAL_SAMPLE_W-1:0] volt_out
);
    // Fixed latency of MAX_ADV steps is the zero point; advance shortens it.
    phcal_pkg::phcal_sample_t line_r [`PHCAL_LINE_DEPTH];
    phcal_pkg::phcal_sample_t line_nxt [`PHCAL_LINE_DEPTH];
    logic [`PHCAL_IDX_W-1:0] tap;
    logic [`PHCAL_SAMPLE_W-1:0] volt_r;
    logic [`PHCAL_SAMPLE_W-1:0] volt_nxt;
    logic [`PHCAL_IDX_W-1:0] mag;

    always_comb begin
        mag = cal_in[`PHCAL_IDX_W-1:0];
        if (cal_in[`PHCAL_SIGN_BIT]) begin
            // Delay: value minus 512 in low bits, beyond the zero point
            if (mag > `PHCAL_IDX_W'(`PHCAL_MAX_DELAY)) begin
                mag = `PHCAL_IDX_W'(`PHCAL_MAX_DELAY);
            end
            tap = `PHCAL_IDX_W'(`PHCAL_MAX_ADV) + mag;
        end else begin
            // Advance: magnitude subtracted from the zero point
            if (mag > `PHCAL_IDX_W'(`PHCAL_MAX_ADV)) begin
                mag = `PHCAL_IDX_W'(`PHCAL_MAX_ADV);
            end
            tap = `PHCAL_IDX_W'(`PHCAL_MAX_ADV) - mag;
        end
        line_nxt[0] = tick_in ? volt_in : line_r[0];
        for (int i = 1; i < `PHCAL_LINE_DEPTH; i++) begin
            line_nxt[i] = tick_in ? line_r[i-1] : line_r[i];
        end
        // Tap read each tick so a new value applies to the next sample
        volt_nxt = tick_in ? line_r[tap] : volt_r;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < `PHCAL_LINE_DEPTH; i++) begin
                line_r[i] <= '0;
            end
            volt_r <= '0;
        end else begin
            line_r <= line_nxt;
            volt_r <= volt_nxt;
        end
    end

    assign volt_out = volt_r;
endmodule : phcal_lane
`default_nettype wire

// *** phcal_params.svh ***
// Constants for the per-phase timing correction block.
// Assumes inclusion by the package, the lane and the top module.
`ifndef PHCAL_PARAMS_SVH
`define PHCAL_PARAMS_SVH

`define PHCAL_CAL_W 10
`define PHCAL_SAMPLE_W 24
`define PHCAL_WORD_W 28
`define PHCAL_BUS_W 32
`define PHCAL_ADDR_W 4
// Register byte offsets
`define PHCAL_OFS_A 4'h0
`define PHCAL_OFS_B 4'h4
`define PHCAL_OFS_C 4'h8
`define PHCAL_OFS_CFG2 4'hC
// Field layout
`define PHCAL_SIGN_BIT 9
`define PHCAL_EXTREF_BIT 0
`define PHCAL_CAL_RST 10'h000
`define PHCAL_CFG2_RST 1'b0
// Processing clock: 1024 kHz from a 250000 kHz system clock
`define PHCAL_SYS_KHZ 250000
`define PHCAL_PROC_KHZ 1024
`define PHCAL_TICK_CYC ((`PHCAL_SYS_KHZ) / (`PHCAL_PROC_KHZ))
`define PHCAL_TICK_W 8
// Delay line: 63 steps of delay, 383 of advance
`define PHCAL_MAX_DELAY 63
`define PHCAL_MAX_ADV 383
`define PHCAL_LINE_DEPTH 447
`define PHCAL_IDX_W 9

`endif

// *** phcal_pkg.sv ***
// Types for the per-phase timing correction block.
// Assumes the constants header is available on the include path.
`default_nettype none
`include "phcal_params.svh"
package phcal_pkg;
    typedef logic [`PHCAL_CAL_W-1:0] phcal_cal_t;
    typedef logic [`PHCAL_SAMPLE_W-1:0] phcal_sample_t;
    typedef enum logic [1:0] {PHCAL_PM_FULL, PHCAL_PM_RED1, PHCAL_PM_RED2, PHCAL_PM_RED3} phcal_pmode_t;
    typedef enum {PHCAL_BUS_IDLE, PHCAL_BUS_ACK} phcal_bus_state_t;
endpackage : phcal_pkg
`default_nettype wire

// *** phcal_top.sv ***
// Per-phase timing correction of the voltage sample streams, with
// calibration and reference-select registers on a classic Wishbone slave.
// Assumes samples and power mode come from logic on the same clock.
`default_nettype none
`include "phcal_params.svh"
module phcal_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [`PHCAL_ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [`PHCAL_BUS_W-1:0] wb_dat_in,
    output logic [`PHCAL_BUS_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    // Power mode
    input wire phcal_pkg::phcal_pmode_t pmode_in,
    // Voltage samples
    input wire logic sample_valid_in,
    input wire phcal_pkg::phcal_sample_t volt_a_in,
    input wire phcal_pkg::phcal_sample_t volt_b_in,
    input wire phcal_pkg::phcal_sample_t volt_c_in,
    output logic [`PHCAL_SAMPLE_W-1:0] volt_a_out,
    output logic [`PHCAL_SAMPLE_W-1:0] volt_b_out,
    output logic [`PHCAL_SAMPLE_W-1:0] volt_c_out,
    // Processing-rate tick and reference choice
    output logic tick_out,
    output logic ext_ref_sel_out
);
    phcal_pkg::phcal_cal_t cal_r [3];
    phcal_pkg::phcal_cal_t cal_nxt [3];
    logic ext_ref_r;
    logic ext_ref_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [`PHCAL_BUS_W-1:0] rdat_r;
    logic [`PHCAL_BUS_W-1:0] rdat_nxt;
    logic [`PHCAL_TICK_W-1:0] tick_cnt_r;
    logic [`PHCAL_TICK_W-1:0] tick_cnt_nxt;
    logic tick_r;
    logic tick_nxt;
    logic [`PHCAL_WORD_W-1:0] word_in;
    logic req;
    logic wr;

    // Processing clock tick, fractional rate rounded to whole cycles
    always_comb begin
        if (tick_cnt_r == `PHCAL_TICK_W'(`PHCAL_TICK_CYC - 1)) begin
            tick_cnt_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            tick_cnt_nxt = tick_cnt_r + `PHCAL_TICK_W'(1);
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // Register bus: answer one cycle after the request, ack drops next cycle
    assign req = wb_cyc_in && wb_stb_in && !ack_r;
    assign wr = req && wb_we_in;
    // Bus word cut to the internal word width, low lanes carry the value
    assign word_in = wb_dat_in[`PHCAL_WORD_W-1:0];

    always_comb begin
        ack_nxt = req;
        rdat_nxt = rdat_r;
        ext_ref_nxt = ext_ref_r;
        for (int i = 0; i < 3; i++) begin
            cal_nxt[i] = cal_r[i];
        end
        if (wr && wb_sel_in[0] && wb_sel_in[1]) begin
            case (wb_adr_in)
                `PHCAL_OFS_A: cal_nxt[0] = word_in[`PHCAL_CAL_W-1:0];
                `PHCAL_OFS_B: cal_nxt[1] = word_in[`PHCAL_CAL_W-1:0];
                `PHCAL_OFS_C: cal_nxt[2] = word_in[`PHCAL_CAL_W-1:0];
                `PHCAL_OFS_CFG2: begin
                    // Writes outside full operation are dropped, so the bit holds
                    if (pmode_in == phcal_pkg::PHCAL_PM_FULL) begin
                        ext_ref_nxt = word_in[`PHCAL_EXTREF_BIT];
                    end
                end
                default: ;
            endcase
        end
        if (req && !wb_we_in) begin
            case (wb_adr_in)
                `PHCAL_OFS_A: rdat_nxt = {22'h000000, cal_r[0]};
                `PHCAL_OFS_B: rdat_nxt = {22'h000000, cal_r[1]};
                `PHCAL_OFS_C: rdat_nxt = {22'h000000, cal_r[2]};
                `PHCAL_OFS_CFG2: rdat_nxt = {31'h00000000, ext_ref_r};
                default: rdat_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 3; i++) begin
                cal_r[i] <= `PHCAL_CAL_RST;
            end
            ext_ref_r <= `PHCAL_CFG2_RST;
            ack_r <= 1'b0;
            rdat_r <= '0;
        end else begin
            cal_r <= cal_nxt;
            ext_ref_r <= ext_ref_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = rdat_r;
    assign ext_ref_sel_out = ext_ref_r;
    assign tick_out = tick_r;

    // Samples enter on the tick; the source is expected to hold valid until then
    phcal_lane lane_a (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_in(tick_r && sample_valid_in),
        .volt_in(volt_a_in),
        .cal_in(cal_r[0]),
        .volt_out(volt_a_out)
    );
    phcal_lane lane_b (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_in(tick_r && sample_valid_in),
        .volt_in(volt_b_in),
        .cal_in(cal_r[1]),
        .volt_out(volt_b_out)
    );
    phcal_lane lane_c (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_in(tick_r && sample_valid_in),
        .volt_in(volt_c_in),
        .cal_in(cal_r[2]),
        .volt_out(volt_c_out)
    );
endmodule : phcal_top
`default_nettype wire

// *** phcal_top_asserts.sv ***
// Port checker for phcal_top: bus handshake, tick spacing, reference select.
// Assumes it is bound into phcal_top by the statement at the foot.
`default_nettype none
module phcal_top_asserts (
    // Clock and bus
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    // Datapath
    input wire phcal_pkg::phcal_pmode_t pmode_in,
    input wire logic sample_valid_in,
    input wire logic [23:0] volt_a_out,
    input wire logic tick_out,
    input wire logic ext_ref_sel_out
);
    logic [7:0] gap_r;
    logic [7:0] gap_nxt;
    logic seen_r;
    logic take;
    assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
    always_comb gap_nxt = tick_out ? 8'h00 : gap_r + 8'h01;
    // First gap after reset is not judged
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap_r <= 8'h00;
            seen_r <= 1'b0;
        end else begin
            gap_r <= gap_nxt;
            seen_r <= seen_r | tick_out;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_ack_once; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");
    property p_ack_due; take |=> wb_ack_out; endproperty
    a_ack_due: assert property (p_ack_due) else $error("no ack");
    property p_pad; wb_ack_out |-> wb_dat_out[31:10] == 22'h0; endproperty
    a_pad: assert property (p_pad) else $error("upper bits set");
    property p_tick_gap; tick_out && seen_r |-> gap_r == 8'hF3; endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing");
    property p_tick_due; seen_r |-> gap_r < 8'hF4; endproperty
    a_tick_due: assert property (p_tick_due) else $error("tick late");
    property p_ref_set; take && wb_we_in && wb_adr_in == 4'hC && wb_sel_in[1:0] == 2'h3
        && pmode_in == phcal_pkg::PHCAL_PM_FULL |=> ext_ref_sel_out == $past(wb_dat_in[0]);
    endproperty
    a_ref_set: assert property (p_ref_set) else $error("reference select");
    property p_ref_keep; pmode_in != phcal_pkg::PHCAL_PM_FULL |=> $stable(ext_ref_sel_out);
    endproperty
    a_ref_keep: assert property (p_ref_keep) else $error("reference lost");
    property p_hold; !$past(tick_out && sample_valid_in) |-> $stable(volt_a_out); endproperty
    a_hold: assert property (p_hold) else $error("sample moved");
endmodule : phcal_top_asserts
bind phcal_top phcal_top_asserts chk_u (.clk_in(clk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pmode_in(pmode_in),
    .sample_valid_in(sample_valid_in), .volt_a_out(volt_a_out), .tick_out(tick_out),
    .ext_ref_sel_out(ext_ref_sel_out));
`default_nettype wire

// *** phcal_top_tb.sv ***
// Self-checking bench for phcal_top: registers, reference retention, lane shifts.
// Assumes the 244-cycle processing tick of the design.
`default_nettype none
module phcal_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_in, cyc, stb, we, ack, vld, tick, xref;
    logic [3:0] adr, sel, bsel;
    logic [31:0] wd, rd, q;
    logic [23:0] va, vb, vc, oa, ob, oc;
    phcal_pkg::phcal_pmode_t pm;
    int fails, tests_run, cycles;
    phcal_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rd),
        .wb_ack_out(ack), .pmode_in(pm), .sample_valid_in(vld), .volt_a_in(va),
        .volt_b_in(vb), .volt_c_in(vc), .volt_a_out(oa), .volt_b_out(ob), .volt_c_out(oc),
        .tick_out(tick), .ext_ref_sel_out(xref));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
        sel <= bsel;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rd;
        {cyc, stb} <= 2'h0;
        @(posedge clk_in);
        if (n >= 50) begin
            fails++;
            $display("wrong value at %0t: no bus answer", $time);
        end
    endtask : wb
    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 4'(i * 4), 32'h0);
            chk(q, 32'h0);
        end
        wb(1'b1, 4'h0, 32'hFFFFFFFF);
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h000003FF);
        wb(1'b1, 4'h1, 32'h0000017F);
        wb(1'b0, 4'h1, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h000003FF);
        // Write without the low byte lanes must be ignored
        bsel = 4'h0;
        wb(1'b1, 4'h0, 32'h00000155);
        bsel = 4'hF;
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h000003FF);
        wb(1'b1, 4'h0, 32'h0000023F);
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0000023F);
    endtask : t_regs
    task automatic t_ref;
        wb(1'b1, 4'hC, 32'h00000001);
        chk({31'h0, xref}, 32'h1);
        for (int i = 1; i < 4; i++) begin
            pm <= phcal_pkg::phcal_pmode_t'(i);
            wb(1'b1, 4'hC, 32'h0);
            chk({31'h0, xref}, 32'h1);
        end
        pm <= phcal_pkg::PHCAL_PM_FULL;
        wb(1'b1, 4'hC, 32'h0);
        chk({31'h0, xref}, 32'h0);
    endtask : t_ref
    task automatic t_stream;
        int n, e;
        // Advances of 383, 380 and 382 steps: outputs lag 1, 4 and 2 ticks
        wb(1'b1, 4'h0, 32'h0000017F);
        wb(1'b1, 4'h4, 32'h0000017C);
        wb(1'b1, 4'h8, 32'h0000017E);
        for (int k = 1; k < 10; k++) begin
            vld <= (k < 9);
            {va, vb, vc} <= {3{24'(k)}};
            e = (k < 9) ? k : 8;
            n = 0;
            do begin
                @(posedge clk_in);
                n++;
            end while (tick !== 1'b1 && n < 300);
            if (n >= 300) begin
                fails++;
                $display("wrong value at %0t: no processing tick", $time);
            end
            repeat (2) @(posedge clk_in);
            chk({8'h0, oa}, 32'(e - 1));
            chk({8'h0, ob}, 32'(e > 4 ? e - 4 : 0));
            chk({8'h0, oc}, 32'(e > 2 ? e - 2 : 0));
        end
    endtask : t_stream
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        {cyc, stb, we, vld, adr, wd, va, vb, vc} = '0;
        sel = 4'hF;
        bsel = 4'hF;
        rst_in = 1'b1;
        pm = phcal_pkg::PHCAL_PM_FULL;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_regs();
        t_ref();
        t_stream();
        end_of_test();
    end
endmodule : phcal_top_tb
`default_nettype wire
